// File: core/event_route_pkg.sv
`default_nettype none

package event_route_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] STATUS_ADDR   = 8'h0f;
  localparam logic [7:0] PIN_ONE_ADDR  = 8'h2a;
  localparam logic [7:0] PIN_TWO_ADDR  = 8'h2b;
  localparam logic [7:0] RATE_CFG_ADDR = 8'h2c;

  localparam logic [7:0] PIN_ROUTE_RESET = 8'h00;
  localparam logic [7:0] RATE_CFG_RESET  = 8'h13;
  localparam logic [7:0] UNMAPPED_READ   = 8'h00;

  // ---------------------------------------------------------------
  // Field layout
  // ---------------------------------------------------------------
  localparam int NUM_SOURCES    = 7;
  localparam int POLARITY_BIT   = 7;
  localparam int RANGE_MSB      = 7;
  localparam int RANGE_LSB      = 6;
  localparam int RESERVED_BIT   = 5;
  localparam int NARROW_BW_BIT  = 4;
  localparam int EXT_TRIG_BIT   = 3;
  localparam int RATE_MSB       = 2;
  localparam int RATE_LSB       = 0;

  // Source positions inside the routing and status words
  localparam int SRC_NEW_SAMPLE = 0;
  localparam int SRC_Q_READY    = 1;
  localparam int SRC_Q_WMARK    = 2;
  localparam int SRC_Q_OVERRUN  = 3;
  localparam int SRC_OVER_THR   = 4;
  localparam int SRC_UNDER_THR  = 5;
  localparam int SRC_AWAKE      = 6;

  // Range and rate codes after normalisation
  localparam logic [1:0] RANGE_2G   = 2'h0;
  localparam logic [1:0] RANGE_4G   = 2'h1;
  localparam logic [1:0] RANGE_8G   = 2'h2;
  localparam logic [2:0] RATE_400HZ = 3'h5;

  typedef struct packed {
    logic                   active_low;
    logic [NUM_SOURCES-1:0] sources;
  } pin_route_t;

  typedef struct packed {
    logic [1:0] range;
    logic       reserved;
    logic       narrow_filter_select;
    logic       external_trigger_select;
    logic [2:0] rate;
  } rate_cfg_t;

endpackage

`default_nettype wire

// File: core/interrupt_routing_and_rate_config.sv
// Overview of operation
// - Low seven routing bits enable sources
// - Top routing bit one makes pin low-active
// - Pin asserts on OR of enabled sources
// - No source routed: pin not driven
// - Fixed source order, awake down to sample
// - Second routing register drives pin two
// - Status register shows every raw source
// - Range field selects 2, 4, 8 g
// - Narrow bit picks quarter or half bandwidth
// - Bit three takes timing from pin two
// - Rate field selects 12.5 to 400 Hz
`timescale 1ns/10ps
`default_nettype none

module interrupt_routing_and_rate_config
  import event_route_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  input  wire logic [7:0]             reg_addr,
  input  wire logic [7:0]             reg_wdata,
  output var  logic [7:0]             reg_rdata,
  output var  logic                   status_read,
  input  wire logic [NUM_SOURCES-1:0] event_sources,
  output var  logic                   event_pin_one_out,
  output var  logic                   event_pin_one_oe,
  input  wire logic                   event_pin_two_in,
  output var  logic                   event_pin_two_out,
  output var  logic                   event_pin_two_oe,
  output var  logic                   ext_trigger,
  output var  logic [1:0]             range_sel,
  output var  logic                   narrow_filter_select,
  output var  logic                   external_trigger_select,
  output var  logic [2:0]             rate_sel
);

  // ---------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------
  function automatic logic pin_level(input pin_route_t r,
                                     input logic [NUM_SOURCES-1:0] s);
    logic hit;
    hit = |(r.sources & s);
    pin_level = r.active_low ? ~hit : hit;
  endfunction

  function automatic logic [1:0] range_decode(input logic [1:0] c);
    range_decode = c[1] ? RANGE_8G : (c[0] ? RANGE_4G : RANGE_2G);
  endfunction

  function automatic logic [2:0] rate_decode(input logic [2:0] c);
    rate_decode = (c > RATE_400HZ) ? RATE_400HZ : c;
  endfunction

  pin_route_t pin_one_route;
  pin_route_t pin_two_route;
  rate_cfg_t  rate_range_config;
  logic       pin_two_sync1;
  logic       pin_two_sync2;
  logic       pin_two_prev;

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_one_route <= pin_route_t'(PIN_ROUTE_RESET);
    end else if (reg_wr && reg_addr == PIN_ONE_ADDR) begin
      pin_one_route <= pin_route_t'(reg_wdata);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_two_route <= pin_route_t'(PIN_ROUTE_RESET);
    end else if (reg_wr && reg_addr == PIN_TWO_ADDR) begin
      pin_two_route <= pin_route_t'(reg_wdata);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rate_range_config <= rate_cfg_t'(RATE_CFG_RESET);
    end else if (reg_wr && reg_addr == RATE_CFG_ADDR) begin
      rate_range_config <= rate_cfg_t'(reg_wdata);
    end
  end

  // ---------------------------------------------------------------
  // Register reads
  // ---------------------------------------------------------------
  // Read data lands one cycle after the strobe; a status read also
  // pulses status_read so detectors can clear their latched events.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= UNMAPPED_READ;
    end else if (reg_rd) begin
      case (reg_addr)
        STATUS_ADDR:   reg_rdata <= {1'b0, event_sources};
        PIN_ONE_ADDR:  reg_rdata <= pin_one_route;
        PIN_TWO_ADDR:  reg_rdata <= pin_two_route;
        RATE_CFG_ADDR: reg_rdata <= rate_range_config;
        default:       reg_rdata <= UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_read <= 1'b0;
    end else begin
      status_read <= reg_rd && reg_addr == STATUS_ADDR;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt pins
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      event_pin_one_out <= 1'b0;
      event_pin_one_oe  <= 1'b0;
    end else begin
      event_pin_one_out <= pin_level(pin_one_route, event_sources);
      event_pin_one_oe  <= |pin_one_route.sources;
    end
  end

  // Pin two turns into a trigger input while external timing is on,
  // so the routing is parked then to avoid fighting the driver.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      event_pin_two_out <= 1'b0;
      event_pin_two_oe  <= 1'b0;
    end else begin
      event_pin_two_out <= pin_level(pin_two_route, event_sources);
      event_pin_two_oe  <= (|pin_two_route.sources) &&
                           !rate_range_config.external_trigger_select;
    end
  end

  // ---------------------------------------------------------------
  // External trigger on pin two
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_two_sync1 <= 1'b0;
      pin_two_sync2 <= 1'b0;
      pin_two_prev  <= 1'b0;
    end else begin
      pin_two_sync1 <= event_pin_two_in;
      pin_two_sync2 <= pin_two_sync1;
      pin_two_prev  <= pin_two_sync2;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_trigger <= 1'b0;
    end else begin
      ext_trigger <= rate_range_config.external_trigger_select &&
                     pin_two_sync2 && !pin_two_prev;
    end
  end

  // ---------------------------------------------------------------
  // Configuration outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      range_sel               <= RANGE_2G;
      narrow_filter_select    <= RATE_CFG_RESET[NARROW_BW_BIT];
      external_trigger_select <= RATE_CFG_RESET[EXT_TRIG_BIT];
      rate_sel                <= RATE_CFG_RESET[RATE_MSB:RATE_LSB];
    end else begin
      range_sel               <= range_decode(rate_range_config.range);
      narrow_filter_select <= rate_range_config.narrow_filter_select;
      external_trigger_select <= rate_range_config.external_trigger_select;
      rate_sel                <= rate_decode(rate_range_config.rate);
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  pin_one_level_a: assert property (@(posedge clk) disable iff (!arst_n)
    event_pin_one_out == ($past(pin_one_route.active_low) ^
      |($past(pin_one_route.sources) & $past(event_sources))))
    else $error("pin one level wrong");

  pin_two_polar_a: assert property (@(posedge clk) disable iff (!arst_n)
    ($past(pin_two_route.active_low) &&
     ($past(pin_two_route.sources & event_sources) == 7'h00))
      |-> event_pin_two_out)
    else $error("low-active idle pin not high");

  pin_or_hit_a: assert property (@(posedge clk) disable iff (!arst_n)
    (|(pin_one_route.sources & event_sources)) |=>
      event_pin_one_out != $past(pin_one_route.active_low))
    else $error("enabled source did not assert pin");

  pin_float_a: assert property (@(posedge clk) disable iff (!arst_n)
    (pin_one_route.sources == 7'h00) |=> !event_pin_one_oe)
    else $error("unrouted pin driven");

  pin_two_drive_a: assert property (@(posedge clk) disable iff (!arst_n)
    (|pin_two_route.sources && !rate_range_config.external_trigger_select)
      |=> event_pin_two_oe)
    else $error("routed pin two not driven");

  status_view_a: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_rd && reg_addr == STATUS_ADDR) |=>
      (reg_rdata == {1'b0, $past(event_sources)} && status_read))
    else $error("status read wrong");

  range_map_a: assert property (@(posedge clk) disable iff (!arst_n)
    $past(rate_range_config.range[1]) |-> range_sel == RANGE_8G)
    else $error("range code 1x not 8 g");

  rate_clip_a: assert property (@(posedge clk) disable iff (!arst_n)
    rate_sel == ($past(rate_range_config.rate) > RATE_400HZ ?
                 RATE_400HZ : $past(rate_range_config.rate)))
    else $error("rate decode wrong");

  ext_trig_a: assert property (@(posedge clk) disable iff (!arst_n)
    ext_trigger |-> $past(rate_range_config.external_trigger_select) &&
      !event_pin_two_oe ##1 !ext_trigger)
    else $error("trigger without external mode");

  narrow_bw_a: assert property (@(posedge clk) disable iff (!arst_n)
    narrow_filter_select == $past(rate_range_config.narrow_filter_select))
    else $error("bandwidth select lags");

  pin_one_drive_a: assert property (@(posedge clk) disable iff (!arst_n)
    (|pin_one_route.sources) |=> event_pin_one_oe)
    else $error("routed pin one not driven");

  pin_one_polar_a: assert property (@(posedge clk) disable iff (!arst_n)
    ($past(pin_one_route.active_low) &&
     ($past(pin_one_route.sources & event_sources) == 7'h00))
      |-> event_pin_one_out)
    else $error("low-active idle pin one not high");

  pin_one_order_a: assert property (@(posedge clk) disable iff (!arst_n)
    (pin_one_route.sources == 7'h40 && !pin_one_route.active_low &&
     event_sources[SRC_AWAKE]) |=> event_pin_one_out)
    else $error("awake source not on bit six");

  pin_two_order_a: assert property (@(posedge clk) disable iff (!arst_n)
    (pin_two_route.sources == 7'h01 && event_sources[SRC_NEW_SAMPLE] &&
     !rate_range_config.external_trigger_select) |=>
      (event_pin_two_oe &&
       event_pin_two_out != $past(pin_two_route.active_low)))
    else $error("new sample source not on bit zero");

  pin_two_level_a: assert property (@(posedge clk) disable iff (!arst_n)
    event_pin_two_out == ($past(pin_two_route.active_low) ^
      |($past(pin_two_route.sources) & $past(event_sources))))
    else $error("pin two level wrong");

  pin_two_float_a: assert property (@(posedge clk) disable iff (!arst_n)
    (pin_two_route.sources == 7'h00) |=> !event_pin_two_oe)
    else $error("unrouted pin two driven");

  pin_two_park_a: assert property (@(posedge clk) disable iff (!arst_n)
    rate_range_config.external_trigger_select |=> !event_pin_two_oe)
    else $error("pin two driven in trigger mode");

  trig_edge_a: assert property (@(posedge clk) disable iff (!arst_n)
    ($rose(pin_two_sync2) && rate_range_config.external_trigger_select)
      |=> ext_trigger)
    else $error("trigger edge missed");

  ext_copy_a: assert property (@(posedge clk) disable iff (!arst_n)
    external_trigger_select ==
      $past(rate_range_config.external_trigger_select))
    else $error("trigger select lags");

  status_pulse_a: assert property (@(posedge clk) disable iff (!arst_n)
    status_read |-> $past(reg_rd && reg_addr == STATUS_ADDR))
    else $error("status pulse without status read");

  rdata_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    !$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data changed without read");

  route_store_a: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_wr && reg_addr == PIN_TWO_ADDR) |=>
      pin_two_route == $past(reg_wdata))
    else $error("pin two routing not stored");

  cfg_store_a: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_wr && reg_addr == RATE_CFG_ADDR) |=>
      rate_range_config == $past(reg_wdata))
    else $error("rate config not stored");

  range_four_a: assert property (@(posedge clk) disable iff (!arst_n)
    ($past(rate_range_config.range) == 2'h1) |-> range_sel == RANGE_4G)
    else $error("range code 01 not 4 g");

  range_two_a: assert property (@(posedge clk) disable iff (!arst_n)
    ($past(rate_range_config.range) == 2'h0) |-> range_sel == RANGE_2G)
    else $error("range code 00 not 2 g");

  rate_keep_a: assert property (@(posedge clk) disable iff (!arst_n)
    ($past(rate_range_config.rate) < RATE_400HZ) |->
      rate_sel == $past(rate_range_config.rate))
    else $error("low rate code altered");

endmodule

`default_nettype wire

// File: sim/host_pin_model.sv
`timescale 1ns/10ps
`default_nettype none

// ---------------------------------------------------------------
// Host side of both event pins, keepers included
// ---------------------------------------------------------------
module host_pin_model (
  input  wire logic clk,
  input  wire logic one_out,
  input  wire logic one_oe,
  input  wire logic two_out,
  input  wire logic two_oe,
  input  wire logic trig_en,
  input  wire logic trig_level,
  output var  logic one_level,
  output var  logic two_level
);
  logic keep_one = 1'b0;
  logic keep_two = 1'b0;

  // Keeper holds the last level seen once nobody drives
  always_comb one_level = one_oe ? one_out : keep_one;
  // Host drives the trigger only while the device lets go
  always_comb two_level = two_oe ? two_out :
                          (trig_en ? trig_level : keep_two);
  always_ff @(posedge clk) begin
    keep_one <= one_level;
    keep_two <= two_level;
  end
endmodule

`default_nettype wire

// File: sim/test_interrupt_routing_and_rate_config.sv
`timescale 1ns/10ps
`default_nettype none

module test_interrupt_routing_and_rate_config;
  import event_route_pkg::*;
  logic                   clk = 1'b0;
  logic                   arst_n = 1'b0;
  logic                   reg_wr = 1'b0;
  logic                   reg_rd = 1'b0;
  logic [7:0]             reg_addr = 8'h00;
  logic [7:0]             reg_wdata = 8'h00;
  logic [7:0]             reg_rdata;
  logic                   status_read;
  logic [NUM_SOURCES-1:0] event_sources = 7'h00;
  logic                   event_pin_one_out, event_pin_one_oe;
  logic                   event_pin_two_in;
  logic                   event_pin_two_out, event_pin_two_oe;
  logic                   ext_trigger, narrow_filter_select;
  logic                   external_trigger_select;
  logic [1:0]             range_sel;
  logic [2:0]             rate_sel;
  logic                   trig_en = 1'b0;
  logic                   trig_level = 1'b0;
  logic                   one_level, st;
  logic [7:0]             rd_val, cv;
  logic [2:0]             c;
  int                     num_errors = 0;
  int                     checked = 0;
  int                     pulses;

  always #5 clk = ~clk;

  interrupt_routing_and_rate_config dut (.clk, .arst_n, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .status_read, .event_sources,
    .event_pin_one_out, .event_pin_one_oe, .event_pin_two_in,
    .event_pin_two_out, .event_pin_two_oe, .ext_trigger, .range_sel,
    .narrow_filter_select, .external_trigger_select, .rate_sel);

  host_pin_model host (.clk, .one_out(event_pin_one_out),
    .one_oe(event_pin_one_oe), .two_out(event_pin_two_out),
    .two_oe(event_pin_two_oe), .trig_en, .trig_level, .one_level,
    .two_level(event_pin_two_in));

  // ---------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------
  task automatic give_verdict;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data and the status pulse both settle just after the taking edge
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
    st = status_read;
  endtask

  task automatic pins(input logic [6:0] s);
    @(posedge clk);
    event_sources <= s;
    repeat (2) @(posedge clk);
    #1;
  endtask

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    #1;
    cmp({6'h00, range_sel}, 8'h00);
    cmp({7'h00, narrow_filter_select}, 8'h01);
    cmp({5'h00, rate_sel}, 8'h03);
    cmp({6'h00, event_pin_one_oe, event_pin_two_oe}, 8'h00);
    rd(RATE_CFG_ADDR);
    cmp(rd_val, 8'h13);
    rd(PIN_ONE_ADDR);
    cmp(rd_val, 8'h00);
    rd(PIN_TWO_ADDR);
    cmp(rd_val, 8'h00);
    rd(8'h3c);
    cmp(rd_val, 8'h00);
    for (int i = 0; i < 7; i++) begin
      wr(PIN_ONE_ADDR, 8'h01 << i);
      wr(PIN_TWO_ADDR, 8'h80 | (8'h01 << i));
      pins(7'h01 << i);
      cmp({event_pin_one_oe, event_pin_one_out}, 8'h03);
      cmp({event_pin_two_oe, event_pin_two_out}, 8'h02);
      pins(~(7'h01 << i));
      cmp({event_pin_one_oe, event_pin_one_out}, 8'h02);
      cmp({event_pin_two_oe, event_pin_two_out}, 8'h03);
    end
    wr(PIN_ONE_ADDR, 8'h7f);
    pins(7'h20);
    cmp({event_pin_one_oe, event_pin_one_out}, 8'h03);
    rd(STATUS_ADDR);
    cmp(rd_val, 8'h20);
    cmp({7'h00, st}, 8'h01);
    // Pin one low-active: asserted low, idle high
    wr(PIN_ONE_ADDR, 8'hff);
    pins(7'h08);
    cmp({event_pin_one_oe, event_pin_one_out}, 8'h02);
    pins(7'h00);
    cmp({event_pin_one_oe, event_pin_one_out}, 8'h03);
    wr(PIN_ONE_ADDR, 8'h00);
    pins(7'h7f);
    cmp({event_pin_one_oe, one_level}, 8'h01);
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      cv = {c[1:0], c[2], c[0], 1'b0, c};
      wr(RATE_CFG_ADDR, cv);
      rd(RATE_CFG_ADDR);
      cmp(rd_val, cv);
      cmp({6'h00, range_sel}, c[1] ? 8'h02 : {7'h00, c[0]});
      cmp({7'h00, narrow_filter_select}, {7'h00, c[0]});
      cmp({5'h00, rate_sel}, (i > 5) ? 8'h05 : {5'h00, c});
    end
    wr(PIN_TWO_ADDR, 8'h01);
    wr(RATE_CFG_ADDR, 8'h08);
    pins(7'h01);
    cmp({event_pin_two_oe, external_trigger_select}, 8'h01);
    @(posedge clk);
    trig_en <= 1'b1;
    repeat (4) @(posedge clk);
    trig_level <= 1'b1;
    pulses = 0;
    repeat (8) begin
      @(posedge clk);
      #1;
      if (ext_trigger === 1'b1)
        pulses++;
    end
    cmp(pulses[7:0], 8'h01);
    give_verdict();
  end

  // Whole sequence needs well under a thousand cycles
  initial begin
    #100000;
    num_errors++;
    give_verdict();
  end
endmodule

`default_nettype wire
